//--- src/trsl_top.sv
// torque reference front end: offset removal, lag filter, preset
// selection and the speed limit used in torque control
// assumes analog samples and restart arrive on the core clock; select
// pins, servo-on and panel keys are asynchronous
//
// Contract
// RL1 - offset correction stays within -1024 to +1024, keys included
// RL2 - offset lives outside parameters; factory restore leaves it alone
// RL3 - auto adjust measures the input residual and stores its correction
// RL4 - before auto adjust the partner sets servo off and zero volts
// RL5 - partner asserts servo-on before manual offset display and editing
// RL6 - mode key held one second shows offset; up and down step it
// RL7 - left key held one second returns to the manual adjust display
// RL8 - first order lag, time constant 0 to 2500 x 0.01 ms, default 50
// RL9 - limit source 0 uses the internal speed cap alone
// RL10 - limit source 1 uses lesser of analog speed and internal cap
// RL11 - cap 0 to 6000 rpm, default 1500, held to motor maximum
// RL12 - analog limit scaled by reference gain, polarity ignored
// RL13 - torque mode with torque source 1 uses internal presets only
// RL14 - two select inputs pick torque preset 1 to 4, -400 to 400 %
// RL15 - two limit inputs pick limit preset 1 to 4, +/-6000 rpm
// RL16 - control mode and limit source change only at restart
// RL17 - reference gain 10 to 100 x 0.1 V per 100 %, default 33
// RL18 - offset correction is subtracted before the filter
`timescale 1ns/1ps
module trsl_top #(
  parameter int HOLD_CYC      = trsl_pkg::HOLD_CYC,
  parameter int MOTOR_MAX_RPM = 3000,
  parameter int RATED_RPM     = 3000
)(
  // clock and reset
  input  wire logic               I_CORE_CLK,
  input  wire logic               I_SRST,
  // register port
  input  wire logic [3:0]         I_ADDR,
  input  wire logic [15:0]        I_WDATA,
  input  wire logic               I_WR,
  input  wire logic               I_RD,
  output logic      [15:0]        O_RDATA,
  // analog samples and restart, core clock
  input  wire logic signed [11:0] I_TREF_ADC,
  input  wire logic signed [11:0] I_VREF_ADC,
  input  wire logic               I_RESTART,
  // offset store
  input  wire logic signed [11:0] I_NV_OFFSET,
  output logic                    O_NV_WE,
  output logic signed [11:0]      O_NV_OFFSET,
  // select pins, servo-on and panel keys
  input  wire logic               I_TORQUE_PRESET_SEL0,
  input  wire logic               I_TORQUE_PRESET_SEL1,
  input  wire logic               I_LIMIT_PRESET_SEL0,
  input  wire logic               I_LIMIT_PRESET_SEL1,
  input  wire logic               I_SERVO_ON,
  input  wire logic               I_KEY_MODE,
  input  wire logic               I_KEY_UP,
  input  wire logic               I_KEY_DOWN,
  input  wire logic               I_KEY_LEFT,
  // results
  output logic signed [15:0]      O_TORQUE_CMD,
  output logic [12:0]             O_SPEED_LIMIT,
  output logic                    O_TORQUE_ACTIVE,
  output logic [1:0]              O_PANEL_STATE,
  output logic signed [11:0]      O_DISP_OFFSET
);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam logic signed [15:0] MOT_MAX = 16'(MOTOR_MAX_RPM);

  typedef enum logic [1:0] {PNL_IDLE, PNL_MENU, PNL_VALUE} trsl_pnl_t;
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction
  function automatic logic signed [15:0] min16(
    input logic signed [15:0] a,
    input logic signed [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  // pin synchronisers; stage three only feeds edge detection
  logic [8:0] pin_s1_ff;
  logic [8:0] pin_s2_ff;
  logic [8:0] pin_s3_ff;
  wire  [8:0] pin_raw = {I_KEY_LEFT, I_KEY_DOWN, I_KEY_UP, I_KEY_MODE,
                         I_SERVO_ON, I_LIMIT_PRESET_SEL1,
                         I_LIMIT_PRESET_SEL0, I_TORQUE_PRESET_SEL1,
                         I_TORQUE_PRESET_SEL0};

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
      {pin_s3_ff, pin_s2_ff, pin_s1_ff} <= '0;
    else
      {pin_s3_ff, pin_s2_ff, pin_s1_ff} <= {pin_s2_ff, pin_s1_ff, pin_raw};
  end

  wire [1:0] tidx      = pin_s2_ff[1:0];
  wire [1:0] lidx      = pin_s2_ff[3:2];
  wire       servo_on  = pin_s2_ff[4];
  wire       key_mode  = pin_s2_ff[5];
  wire       key_left  = pin_s2_ff[8];
  wire       up_rise   = pin_s2_ff[6] & ~pin_s3_ff[6];
  wire       down_rise = pin_s2_ff[7] & ~pin_s3_ff[7];
  wire       left_rise = pin_s2_ff[8] & ~pin_s3_ff[8];

  // parameter registers
  logic [3:0]        mode_pend_ff;
  logic [3:0]        mode_act_ff;
  logic              lsrc_pend_ff;
  logic              lsrc_act_ff;
  logic              tsrc_ff;
  logic signed [15:0] gain_ff;
  logic signed [15:0] tc_ff;
  logic signed [15:0] cap_ff;
  logic signed [15:0] tp_ff [4];
  logic signed [15:0] sp_ff [4];

  wire signed [15:0] wd      = I_WDATA;
  wire               wr_cmd  = I_WR && (I_ADDR == trsl_pkg::REG_CMD);
  wire               factory = wr_cmd && I_WDATA[trsl_pkg::CMD_FACTORY];
  wire [1:0]         wsel    = I_ADDR[1:0] - 2'h1;

  // the restore touches parameters only; the offset is held elsewhere
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SRST || factory) // RL2
    begin
      mode_pend_ff <= trsl_pkg::MODE_DEF;
      lsrc_pend_ff <= trsl_pkg::LSRC_DEF;
      tsrc_ff      <= trsl_pkg::TSRC_DEF;
      gain_ff      <= trsl_pkg::GAIN_DEF;
      tc_ff        <= trsl_pkg::TC_DEF;
      cap_ff       <= trsl_pkg::CAP_DEF;
      tp_ff        <= '{default: trsl_pkg::TP_DEF};
      sp_ff        <= trsl_pkg::SP_DEF;
    end
    else if (I_WR)
    begin
      case (I_ADDR)
        trsl_pkg::REG_CTRL:
        begin
          mode_pend_ff <= I_WDATA[3:0];
          lsrc_pend_ff <= I_WDATA[trsl_pkg::CTRL_LSRC];
        end
        trsl_pkg::REG_TSRC: tsrc_ff <= I_WDATA[0];
        trsl_pkg::REG_GAIN: gain_ff <= trsl_pkg::clamp16(wd,
          trsl_pkg::GAIN_MIN, trsl_pkg::GAIN_MAX); // RL17
        trsl_pkg::REG_TC: tc_ff <= trsl_pkg::clamp16(wd,
          trsl_pkg::ZERO16, trsl_pkg::TC_MAX); // RL8
        trsl_pkg::REG_CAP: cap_ff <= trsl_pkg::clamp16(wd,
          trsl_pkg::ZERO16, trsl_pkg::CAP_MAX); // RL11
        4'h5, 4'h6, 4'h7, 4'h8: tp_ff[I_ADDR[1:0] - 2'h1] <=
          trsl_pkg::clamp16(wd, trsl_pkg::TP_MIN, trsl_pkg::TP_MAX); // RL14
        default: ;
      endcase
      if (I_ADDR >= trsl_pkg::REG_SP0 && I_ADDR < trsl_pkg::REG_CMD)
        sp_ff[wsel] <= trsl_pkg::clamp16(wd,
          trsl_pkg::SP_MIN, trsl_pkg::SP_MAX); // RL15
    end
  end

  // mode and limit source only move at restart; a torque source write still
  // switches torque and limit selection at once, servo on or off
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      mode_act_ff <= trsl_pkg::MODE_DEF;
      lsrc_act_ff <= trsl_pkg::LSRC_DEF;
    end
    else if (I_RESTART) // RL16
    begin
      mode_act_ff <= mode_pend_ff;
      lsrc_act_ff <= lsrc_pend_ff;
    end
  end

  // offset correction and panel
  logic signed [11:0] ofs_ff;
  logic signed [11:0] nxt_ofs;
  logic               nv_load_ff;
  logic               nxt_nv_we;
  logic               refused_ff;
  trsl_pnl_t          pnl_ff;
  trsl_pnl_t          nxt_pnl;
  logic [HW-1:0]      hold_ff;

  wire signed [15:0] tref16 = 16'(I_TREF_ADC);
  wire signed [15:0] vref16 = 16'(I_VREF_ADC);
  wire signed [15:0] ofs16  = 16'(ofs_ff);
  wire auto_req  = wr_cmd && I_WDATA[trsl_pkg::CMD_AUTO];
  wire auto_go   = auto_req && !servo_on; // RL4
  wire hold_key  = (pnl_ff == PNL_MENU)  ? key_mode :
                   (pnl_ff == PNL_VALUE) ? key_left : 1'b0;
  wire hold_done = hold_key && (hold_ff == HW'(HOLD_CYC - 1)); // RL6
  wire editing   = (pnl_ff == PNL_VALUE);

  always_comb
  begin
    nxt_ofs   = ofs_ff;
    nxt_nv_we = 1'b0;
    if (nv_load_ff)
      nxt_ofs = 12'(trsl_pkg::clamp16(16'(I_NV_OFFSET),
                trsl_pkg::OFS_MIN, trsl_pkg::OFS_MAX)); // RL2
    else if (auto_go)
    begin
      // the residual seen at zero volts is the correction itself
      nxt_ofs   = 12'(trsl_pkg::clamp16(tref16,
                  trsl_pkg::OFS_MIN, trsl_pkg::OFS_MAX)); // RL3
      nxt_nv_we = 1'b1;
    end
    else if (editing && (up_rise ^ down_rise))
    begin
      nxt_ofs   = 12'(trsl_pkg::clamp16(up_rise ? ofs16 + 16'sh0001
                  : ofs16 - 16'sh0001,
                  trsl_pkg::OFS_MIN, trsl_pkg::OFS_MAX)); // RL1
      nxt_nv_we = (nxt_ofs != ofs_ff);
    end
  end

  always_comb
  begin
    nxt_pnl = pnl_ff;
    case (pnl_ff)
      PNL_IDLE:
        if (wr_cmd && I_WDATA[trsl_pkg::CMD_MANUAL])
          nxt_pnl = PNL_MENU;
      PNL_MENU:
        if (hold_done && servo_on) // RL5
          nxt_pnl = PNL_VALUE; // RL6
        else if (left_rise)
          nxt_pnl = PNL_IDLE;
      PNL_VALUE:
        if (hold_done)
          nxt_pnl = PNL_MENU; // RL7
      default:
        nxt_pnl = PNL_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      ofs_ff      <= '0;
      nv_load_ff  <= 1'b1;
      refused_ff  <= 1'b0;
      pnl_ff      <= PNL_IDLE;
      hold_ff     <= '0;
      O_NV_WE     <= 1'b0;
      O_NV_OFFSET <= '0;
    end
    else
    begin
      ofs_ff      <= nxt_ofs;
      nv_load_ff  <= 1'b0;
      pnl_ff      <= nxt_pnl;
      hold_ff     <= (hold_key && !hold_done) ? hold_ff + HW'(1) : '0;
      O_NV_WE     <= nxt_nv_we;
      O_NV_OFFSET <= nxt_ofs;
      // a refusal in the same cycle as its clear still shows
      if (auto_req && servo_on)
        refused_ff <= 1'b1;
      else if (wr_cmd && I_WDATA[trsl_pkg::CMD_CLR_REF])
        refused_ff <= 1'b0;
    end
  end

  // analog torque percent and analog speed, both scaled by the gain
  wire signed [15:0] corr = tref16 - ofs16; // RL18
  wire [17:0] den = 18'(gain_ff[6:0]) * 18'(trsl_pkg::ADC_FS); // RL17
  wire [31:0] tnum = 32'(mag16(corr)) * 32'(trsl_pkg::PCT_NUM_K);
  wire [31:0] vnum = 32'(mag16(vref16)) * 32'(trsl_pkg::SPD_NUM_K)
                     * 32'(RATED_RPM); // RL12
  wire        t_done;
  wire        v_done;
  wire        t_neg;
  wire [31:0] t_quot;
  wire [31:0] v_quot;
  logic signed [15:0] apct_ff;
  logic signed [15:0] vspd_ff;
  trsl_div #(.NW(32), .DW(18)) u_tdiv (
    .i_clk (I_CORE_CLK), .i_srst (I_SRST), .i_start (1'b1),
    .i_num (tnum), .i_den (den), .i_neg (corr[15]),
    .o_busy (), .o_done (t_done), .o_quot (t_quot), .o_neg (t_neg)
  );
  trsl_div #(.NW(32), .DW(18)) u_vdiv (
    .i_clk (I_CORE_CLK), .i_srst (I_SRST), .i_start (1'b1),
    .i_num (vnum), .i_den (den), .i_neg (1'b0),
    .o_busy (), .o_done (v_done), .o_quot (v_quot), .o_neg ()
  );

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      apct_ff <= '0;
      vspd_ff <= '0;
    end
    else
    begin
      if (t_done)
        apct_ff <= t_neg ? -16'(t_quot) : 16'(t_quot);
      if (v_done)
        vspd_ff <= min16(16'(v_quot), trsl_pkg::CAP_MAX);
    end
  end

  // torque source and lag filter; a step of 1/16 every tc*125 cycles
  // gives tc*10 us, so a new tc acts on the very next step
  wire tq_mode = (mode_act_ff == trsl_pkg::MODE_TORQUE);
  wire signed [15:0] tgt = (tsrc_ff == trsl_pkg::TSRC_INT) ?
                           tp_ff[tidx] : apct_ff; // RL13 RL14
  wire signed [23:0] x24 = {(tq_mode ? tgt : 16'sh0000), 8'h00};
  logic signed [23:0] y_ff;
  logic [19:0]        per_ff;
  wire [19:0] per_lim = 20'(tc_ff[11:0]) * 20'(trsl_pkg::FILT_STEP_CYC);
  wire        tick    = (per_ff + 20'h00001) >= per_lim;
  wire signed [23:0] step = (x24 - y_ff) >>> trsl_pkg::FILT_SHIFT;
  wire signed [23:0] nxt_y = (tc_ff == trsl_pkg::ZERO16) ? x24 :
                             (tick ? y_ff + step : y_ff); // RL8
  // speed limit selection
  wire signed [15:0] cap_eff = min16(cap_ff, MOT_MAX); // RL11
  wire signed [15:0] ext_lim = min16(vspd_ff, cap_eff); // RL10
  wire signed [15:0] pre_lim = min16(16'(mag16(sp_ff[lidx])),
                                     MOT_MAX); // RL15
  wire signed [15:0] lim = (tsrc_ff == trsl_pkg::TSRC_INT) ? pre_lim :
                           (lsrc_act_ff == trsl_pkg::LSRC_EXT) ?
                           ext_lim : cap_eff; // RL9 RL10
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      y_ff            <= '0;
      per_ff          <= '0;
      O_TORQUE_CMD    <= '0;
      O_SPEED_LIMIT   <= '0;
      O_TORQUE_ACTIVE <= 1'b0;
      O_PANEL_STATE   <= '0;
      O_DISP_OFFSET   <= '0;
    end
    else
    begin
      y_ff            <= nxt_y;
      per_ff          <= tick ? 20'h00000 : per_ff + 20'h00001;
      O_TORQUE_CMD    <= nxt_y[23:8];
      O_SPEED_LIMIT   <= lim[12:0];
      O_TORQUE_ACTIVE <= tq_mode;
      O_PANEL_STATE   <= nxt_pnl;
      O_DISP_OFFSET   <= (nxt_pnl == PNL_VALUE) ? nxt_ofs : 12'sh000;
    end
  end

  // read side
  logic [15:0] rword [16];
  assign rword = '{{11'h000, lsrc_pend_ff, mode_pend_ff},
    {15'h0000, tsrc_ff}, gain_ff, tc_ff, cap_ff,
    tp_ff[0], tp_ff[1], tp_ff[2], tp_ff[3],
    sp_ff[0], sp_ff[1], sp_ff[2], sp_ff[3], 16'h0000,
    {8'h00, refused_ff, pnl_ff, lsrc_act_ff, mode_act_ff},
    16'(ofs_ff)};

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
      O_RDATA <= '0;
    else
      O_RDATA <= I_RD ? rword[I_ADDR] : 16'h0000;
  end
endmodule

//--- src/trsl_pkg.sv
// constants shared by the torque reference select and speed limit block
// assumes a 200 MHz core clock and 12-bit signed samples of +/-10 V
package trsl_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int HOLD_TIME_MS  = 1000;
  localparam int HOLD_CYC      = HOLD_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TC_UNIT_NS    = 10000;
  localparam int FILT_SHIFT    = 4;
  localparam int FILT_STEP_CYC = TC_UNIT_NS / CLK_PERIOD_NS
                                 / (1 << FILT_SHIFT);

  // analog scaling: percent = counts * PCT_NUM_K / (ADC_FS * gain)
  localparam int ADC_FS    = 2048;
  localparam int PCT_NUM_K = 10000;
  localparam int SPD_NUM_K = 100;

  // register indices
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_TSRC  = 4'h1;
  localparam logic [3:0] REG_GAIN  = 4'h2;
  localparam logic [3:0] REG_TC    = 4'h3;
  localparam logic [3:0] REG_CAP   = 4'h4;
  localparam logic [3:0] REG_TP0   = 4'h5;
  localparam logic [3:0] REG_SP0   = 4'h9;
  localparam logic [3:0] REG_CMD   = 4'hD;
  localparam logic [3:0] REG_STAT  = 4'hE;
  localparam logic [3:0] REG_OFS   = 4'hF;

  // field positions
  localparam int CTRL_LSRC    = 4;
  localparam int CMD_AUTO     = 0;
  localparam int CMD_MANUAL   = 1;
  localparam int CMD_FACTORY  = 2;
  localparam int CMD_CLR_REF  = 3;

  // encodings and reset values
  localparam logic [3:0] MODE_TORQUE = 4'h2;
  localparam logic [3:0] MODE_DEF    = 4'h2;
  localparam logic       LSRC_EXT    = 1'b1;
  localparam logic       LSRC_DEF    = 1'b0;
  localparam logic       TSRC_INT    = 1'b1;
  localparam logic       TSRC_DEF    = 1'b0;

  // ranges and defaults
  localparam logic signed [15:0] OFS_MIN  = 16'shFC00;
  localparam logic signed [15:0] OFS_MAX  = 16'sh0400;
  localparam logic signed [15:0] TC_MAX   = 16'sh09C4;
  localparam logic signed [15:0] TC_DEF   = 16'sh0032;
  localparam logic signed [15:0] CAP_MAX  = 16'sh1770;
  localparam logic signed [15:0] CAP_DEF  = 16'sh05DC;
  localparam logic signed [15:0] GAIN_MIN = 16'sh000A;
  localparam logic signed [15:0] GAIN_MAX = 16'sh0064;
  localparam logic signed [15:0] GAIN_DEF = 16'sh0021;
  localparam logic signed [15:0] TP_MIN   = 16'shFE70;
  localparam logic signed [15:0] TP_MAX   = 16'sh0190;
  localparam logic signed [15:0] TP_DEF   = 16'sh0000;
  localparam logic signed [15:0] SP_MIN   = 16'shE890;
  localparam logic signed [15:0] SP_MAX   = 16'sh1770;
  localparam logic signed [15:0] ZERO16   = 16'sh0000;
  localparam logic signed [15:0] SP_DEF [4] =
    '{16'sh0064, 16'sh00C8, 16'sh012C, 16'shFF9C};

  function automatic logic signed [15:0] clamp16(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

endpackage

//--- src/trsl_div.sv
// sequential restoring divider, one quotient bit per clock
// assumes a nonzero divisor; a sign tag travels with the operands
`timescale 1ns/1ps
module trsl_div #(
  parameter int NW = 32,
  parameter int DW = 18
)(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_srst,
  // operands
  input  wire logic          i_start,
  input  wire logic [NW-1:0] i_num,
  input  wire logic [DW-1:0] i_den,
  input  wire logic          i_neg,
  // result
  output logic               o_busy,
  output logic               o_done,
  output logic [NW-1:0]      o_quot,
  output logic               o_neg
);
  localparam int CW = $clog2(NW + 1);

  logic [DW:0]   rem_ff;
  logic [NW-1:0] q_ff;
  logic [DW-1:0] den_ff;
  logic [CW-1:0] cnt_ff;
  logic          neg_ff;

  wire [DW:0] trial = {rem_ff[DW-1:0], q_ff[NW-1]};
  wire        fit   = trial >= {1'b0, den_ff};

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rem_ff <= '0;
      q_ff   <= '0;
      den_ff <= '0;
      cnt_ff <= '0;
      neg_ff <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_quot <= '0;
      o_neg  <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (!o_busy && i_start)
      begin
        rem_ff <= '0;
        q_ff   <= i_num;
        den_ff <= i_den;
        cnt_ff <= CW'(NW);
        neg_ff <= i_neg;
        o_busy <= 1'b1;
      end
      else if (o_busy)
      begin
        rem_ff <= fit ? trial - {1'b0, den_ff} : trial;
        q_ff   <= {q_ff[NW-2:0], fit};
        cnt_ff <= cnt_ff - CW'(1);
        if (cnt_ff == CW'(1))
        begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          o_quot <= {q_ff[NW-2:0], fit};
          o_neg  <= neg_ff;
        end
      end
    end
  end
endmodule

//--- verification/trsl_checker.sv
// port assertions for trsl_top
// assumes a bind into trsl_top
`timescale 1ns/1ps
module trsl_checker #(
  parameter int HOLD_CYC      = 20,
  parameter int MOTOR_MAX_RPM = 3000
)(
  // clock, reset and watched inputs
  input wire logic               I_CORE_CLK,
  input wire logic               I_SRST,
  input wire logic               I_RESTART,
  input wire logic               I_SERVO_ON,
  input wire logic               I_KEY_MODE,
  input wire logic               I_KEY_LEFT,
  // watched outputs
  input wire logic               O_NV_WE,
  input wire logic signed [11:0] O_NV_OFFSET,
  input wire logic signed [11:0] O_DISP_OFFSET,
  input wire logic [1:0]         O_PANEL_STATE,
  input wire logic [12:0]        O_SPEED_LIMIT,
  input wire logic               O_TORQUE_ACTIVE
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SRST);

  // counts saturate so a long press never wraps round
  int unsigned mode_cnt_ff;
  int unsigned left_cnt_ff;
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SRST || !(I_KEY_MODE && I_SERVO_ON))
      mode_cnt_ff <= 0;
    else if (mode_cnt_ff < HOLD_CYC)
      mode_cnt_ff <= mode_cnt_ff + 1;
    if (I_SRST || !I_KEY_LEFT)
      left_cnt_ff <= 0;
    else if (left_cnt_ff < HOLD_CYC)
      left_cnt_ff <= left_cnt_ff + 1;
  end

  a_ofs_range:
    assert property (O_NV_OFFSET >= 12'shC00 && O_NV_OFFSET <= 12'sh400)
    else $error("offset out of range");
  a_disp_range:
    assert property (O_PANEL_STATE == 2'h2 |->
      O_DISP_OFFSET >= 12'shC00 && O_DISP_OFFSET <= 12'sh400)
    else $error("shown offset out of range");
  a_disp_hidden:
    assert property (O_PANEL_STATE != 2'h2 |-> O_DISP_OFFSET == 12'sh000)
    else $error("offset shown outside value display");
  a_nv_pulse:
    assert property ($rose(O_NV_WE) |=> !O_NV_WE)
    else $error("store strobe too long");
  // sync flops delay the key, so the hold is read three cycles back
  a_value_hold:
    assert property ($past(O_PANEL_STATE) == 2'h1 && O_PANEL_STATE == 2'h2
      |-> $past(mode_cnt_ff, 3) >= HOLD_CYC - 1)
    else $error("value shown without full mode hold");
  a_menu_return:
    assert property ($past(O_PANEL_STATE) == 2'h2 && O_PANEL_STATE != 2'h2
      |-> O_PANEL_STATE == 2'h1 && $past(left_cnt_ff, 3) >= HOLD_CYC - 1)
    else $error("value display left without full left hold");
  a_speed_cap:
    assert property (O_SPEED_LIMIT <= MOTOR_MAX_RPM)
    else $error("speed limit above motor maximum");
  a_mode_restart:
    assert property ($changed(O_TORQUE_ACTIVE) && !$past(I_SRST)
      && !$past(I_SRST, 2) |-> $past(I_RESTART) || $past(I_RESTART, 2))
    else $error("active mode changed without restart");

  c_value_shown: cover property (O_PANEL_STATE == 2'h2);
  c_nv_write: cover property (O_NV_WE);
  c_mode_left: cover property ($fell(O_TORQUE_ACTIVE));
endmodule

bind trsl_top trsl_checker #(
  .HOLD_CYC      (HOLD_CYC),
  .MOTOR_MAX_RPM (MOTOR_MAX_RPM)
) u_trsl_checker (.*);

//--- verification/trsl_host_model.sv
// host side: offset store, servo-on, torque input
// assumes the bench drives i_manual
`timescale 1ns/1ps
module trsl_host_model #(
  parameter logic signed [11:0] NV_INIT  = 12'sh7FF,
  parameter logic signed [11:0] RESIDUAL = 12'sh030
)(
  // clock and bench requests
  input  wire logic               i_clk,
  input  wire logic               i_manual,
  input  wire logic               i_zero_ref,
  input  wire logic signed [11:0] i_ref_adc,
  // store port
  input  wire logic               i_nv_we,
  input  wire logic signed [11:0] i_nv_offset,
  output logic signed [11:0]      o_nv_offset,
  // drive side
  output logic                    o_servo_on,
  output logic signed [11:0]      o_tref_adc
);
  // the store outlives resets, unlike the parameter set
  logic signed [11:0] store_ff = NV_INIT;
  always @(posedge i_clk)
    if (i_nv_we)
      store_ff <= i_nv_offset;
  assign o_nv_offset = store_ff;
  assign o_servo_on  = i_manual;
  // a zero volt input still reads as the analog residual
  assign o_tref_adc  = i_zero_ref ? RESIDUAL : i_ref_adc;
endmodule

//--- verification/trsl_top_tb.sv
// bench for trsl_top: register, limit, panel, offset, preset tests
// assumes the host model plays store and servo-on
`timescale 1ns/1ps
module trsl_top_tb;
  localparam int HOLD = 20;
  localparam logic [15:0] DF [13] = '{16'h0002, 16'h0000, 16'h0021,
    16'h0032, 16'h05DC, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0064, 16'h00C8, 16'h012C, 16'hFF9C};
  localparam logic [3:0]  CA [5] = '{4'h4, 4'h3, 4'h2, 4'h5, 4'h9};
  localparam logic [15:0] CW [5] = '{16'h1B58, 16'h0BB8, 16'h0005,
    16'h01F4, 16'hE4A8};
  localparam logic [15:0] CE [5] = '{16'h1770, 16'h09C4, 16'h000A,
    16'h0190, 16'hE890};
  localparam logic [15:0] TP [4] = '{16'h000A, 16'h0014, 16'h001E, 16'h0028};
  localparam logic [15:0] LP [4] = '{16'h006F, 16'hFF22, 16'h014D, 16'hF060};
  localparam logic [15:0] LX [4] = '{16'h006F, 16'h00DE, 16'h014D, 16'h0BB8};
  logic               clk, srst, wr, rd, restart, manual, zero_ref;
  logic               nv_we, servo, active;
  logic [3:0]         addr, keys;
  logic [1:0]         tsel, lsel, panel;
  logic [15:0]        wdata, rdata;
  logic [12:0]        limit;
  logic signed [15:0] tcmd;
  logic signed [11:0] ref_adc, vref, tref, nv_in, nv_out, disp;
  int                 failures = 0;
  int                 cmp_count = 0;

  trsl_top #(.HOLD_CYC(HOLD)) i_trsl_top (
    .I_CORE_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TREF_ADC(tref),
    .I_VREF_ADC(vref), .I_RESTART(restart), .I_NV_OFFSET(nv_in),
    .O_NV_WE(nv_we), .O_NV_OFFSET(nv_out),
    .I_TORQUE_PRESET_SEL0(tsel[0]), .I_TORQUE_PRESET_SEL1(tsel[1]),
    .I_LIMIT_PRESET_SEL0(lsel[0]), .I_LIMIT_PRESET_SEL1(lsel[1]),
    .I_SERVO_ON(servo), .I_KEY_MODE(keys[0]), .I_KEY_UP(keys[1]),
    .I_KEY_DOWN(keys[2]), .I_KEY_LEFT(keys[3]), .O_TORQUE_CMD(tcmd),
    .O_SPEED_LIMIT(limit), .O_TORQUE_ACTIVE(active),
    .O_PANEL_STATE(panel), .O_DISP_OFFSET(disp));
  trsl_host_model i_trsl_host_model (
    .i_clk(clk), .i_manual(manual), .i_zero_ref(zero_ref),
    .i_ref_adc(ref_adc), .i_nv_we(nv_we), .i_nv_offset(nv_out),
    .o_nv_offset(nv_in), .o_servo_on(servo), .o_tref_adc(tref));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // every access ends on a rising edge, so calls chain safely
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask

  // sel 0 speed limit, 1 torque command, 2 shown offset
  task automatic wt(input int sel, input logic [15:0] exp);
    logic [15:0] v;
    for (int n = 0; n < 400; n++)
    begin
      @(posedge clk);
      #1 v = sel == 0 ? {3'h0, limit} : sel == 1 ? tcmd : 16'(disp);
      if (v === exp)
        break;
    end
    chk(v, exp);
    @(posedge clk);
  endtask

  task automatic press(input int k, input int n);
    keys[k] <= 1'b1;
    repeat (n) @(posedge clk);
    keys[k] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic restart_pulse();
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    @(posedge clk);
  endtask

  task automatic summarize();
    $display("cmp %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end

  initial
  begin
    srst = 1'b1;
    {wr, rd, restart, manual, keys, tsel, lsel} = 12'h000;
    zero_ref = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    ref_adc = 12'sh000;
    vref = 12'sh000;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 13; i++)
      rd_chk(4'(i), DF[i]);
    rd_chk(4'hF, 16'h0400);
    rd_chk(4'hD, 16'h0000);
    $display("test defaults done");
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(CA[i], CW[i]);
      rd_chk(CA[i], CE[i]);
    end
    wt(0, 16'h0BB8);
    wr_reg(4'h4, 16'h04B0);
    wt(0, 16'h04B0);
    $display("test clamps done");
    wr_reg(4'h0, 16'h0011);
    rd_chk(4'hE, 16'h0002);
    wr_reg(4'h2, 16'h0064);
    vref <= 12'shC00;
    restart_pulse();
    rd_chk(4'hE, 16'h0011);
    chk({15'h0000, active}, 16'h0000);
    wr_reg(4'h0, 16'h0012);
    restart_pulse();
    rd_chk(4'hE, 16'h0012);
    wt(0, 16'h04B0);
    wr_reg(4'h4, 16'h1770);
    wt(0, 16'h05DC);
    vref <= 12'shE00;
    wt(0, 16'h02EE);
    $display("test restart done");
    wr_reg(4'hD, 16'h0002);
    press(0, HOLD + 6);
    rd_chk(4'hE, 16'h0032);
    manual <= 1'b1;
    repeat (4) @(posedge clk);
    press(0, 5);
    rd_chk(4'hE, 16'h0032);
    press(0, HOLD + 6);
    rd_chk(4'hE, 16'h0052);
    wt(2, 16'h0400);
    press(1, 4);
    wt(2, 16'h0400);
    press(2, 4);
    wt(2, 16'h03FF);
    #1 chk({4'h0, nv_in}, 16'h03FF);
    press(3, HOLD + 6);
    rd_chk(4'hE, 16'h0032);
    press(3, 4);
    rd_chk(4'hE, 16'h0012);
    $display("test panel done");
    manual <= 1'b0;
    repeat (4) @(posedge clk);
    wr_reg(4'hD, 16'h0001);
    rd_chk(4'hF, 16'h0030);
    chk({4'h0, nv_in}, 16'h0030);
    wr_reg(4'hD, 16'h0004);
    rd_chk(4'h2, 16'h0021);
    rd_chk(4'hF, 16'h0030);
    manual <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(4'hD, 16'h0001);
    rd_chk(4'hE, 16'h0092);
    wr_reg(4'hD, 16'h0008);
    rd_chk(4'hE, 16'h0012);
    $display("test offset done");
    wr_reg(4'h1, 16'h0001);
    wr_reg(4'h3, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(4'(5 + i), TP[i]);
      wr_reg(4'(9 + i), LP[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      tsel <= 2'(i);
      lsel <= 2'(i);
      wt(1, TP[i]);
      wt(0, LX[i]);
    end
    wr_reg(4'h1, 16'h0000);
    wr_reg(4'h2, 16'h0064);
    zero_ref <= 1'b0;
    ref_adc <= 12'sh230;
    wt(1, 16'h0019);
    wr_reg(4'h3, 16'h0001);
    ref_adc <= 12'sh030;
    repeat (60) @(posedge clk);
    #1 chk({15'h0000, tcmd == 16'sh0000}, 16'h0000);
    @(posedge clk);
    wr_reg(4'h3, 16'h0000);
    wt(1, 16'h0000);
    $display("test presets done");
    summarize();
  end
endmodule
